// [design/display_reset_map.svh]
// Named constants for the display reset sequencer.
// Assumes a single 250 MHz core clock; times are kept in their own unit.
`ifndef DISPLAY_RESET_MAP_SVH
`define DISPLAY_RESET_MAP_SVH
`define CLK_PERIOD_NS 4
`define NS_PER_US 1000
`define RESET_REJECT_NS 5000
`define RESET_VALID_NS 10000
`define COMPLETE_SLEEP_IN_US 5000
`define COMPLETE_SLEEP_OUT_US 120000
`define OTP_WORDS 8
`define OTP_WIDTH 16
`endif

// [design/display_reset_pkg.sv]
// Types shared by the display reset sequencer and its surroundings.
// Assumes the constants header is on the include path.
`include "display_reset_map.svh"
package display_reset_pkg;
  typedef enum {
    ST_IDLE,
    ST_QUALIFY,
    ST_HELD,
    ST_COMPLETE,
    ST_READY
  } seq_state_t;
  typedef struct packed {
    logic ready;
    logic blank;
    logic core_reset;
    logic otp_loaded;
    logic sleep_out_at_reset;
  } seq_status_t;
  typedef struct packed {
    logic rd;
    logic [2:0] addr;
  } otp_req_t;
endpackage

// [design/display_reset_sequencer.sv]
// Reset pin qualification and start-up completion sequencing for a display driver.
// Assumes the reset pin is asynchronous to mclk_in, the sleep state and OTP data
// come from logic on mclk_in, and OTP read data is valid one cycle after a read.
`timescale 1ns/1ns
`include "display_reset_map.svh"
// Contract
// RULE1 - Low pulses under 5 us are ignored; over 10 us always cause full reset.
// RULE2 - Pulses between 5 and 10 us are indeterminate; here they are rejected.
// RULE3 - Host holds the reset pin low at least 10 us for a valid reset.
// RULE4 - Completion ends within 5 ms from sleep-in, 120 ms from sleep-out.
// RULE5 - Display is blanked throughout reset, then returns to default state.
// RULE6 - OTP contents are copied to internal registers within 5 ms of release.
// RULE7 - Host waits at least 5 ms after release before sending commands.
// RULE8 - Host sends no sleep-out command until 120 ms after release.
// RULE9 - Host held reset high at power-up must reset after both supplies are present.
// RULE10 - Host held reset low at power-up keeps it low 10 us after supplies.
// RULE11 - Short high spikes inside a valid low pulse neither end nor restart reset.
// RULE12 - Ready stays low until completion time elapses, gating command decode.
module display_reset_sequencer #(
  parameter int SLEEP_IN_US = `COMPLETE_SLEEP_IN_US,
  parameter int SLEEP_OUT_US = `COMPLETE_SLEEP_OUT_US,
  parameter int OTP_WORDS = `OTP_WORDS,
  parameter int OTP_WIDTH = `OTP_WIDTH
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic reset_input_low_n_in,
  input wire logic sleep_out_in,
  input wire logic [OTP_WIDTH-1:0] otp_data_in,
  input wire logic [2:0] cfg_sel_in,
  output display_reset_pkg::otp_req_t otp_req_out,
  output logic [OTP_WIDTH-1:0] cfg_word_out,
  output display_reset_pkg::seq_status_t status_out
);
  localparam int REJECT_CYC =
    (`RESET_REJECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int VALID_CYC =
    (`RESET_VALID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int TICK_CYC = `NS_PER_US / `CLK_PERIOD_NS;
  localparam int REJECT_US = `RESET_REJECT_NS / `NS_PER_US;
  localparam int PW = $clog2(VALID_CYC + 1);
  localparam int TW = $clog2(SLEEP_OUT_US + 1);
  localparam int DW = $clog2(TICK_CYC);

  logic pin_meta_r;
  logic pin_sync_r;
  display_reset_pkg::seq_state_t state_r;
  logic [PW-1:0] low_cnt_r;
  logic [PW-1:0] high_cnt_r;
  logic [DW-1:0] div_cnt_r;
  logic tick_r;
  logic [TW-1:0] us_cnt_r;
  logic [TW-1:0] limit_r;
  logic sleep_out_r;
  logic [3:0] otp_idx_r;
  logic otp_pend_r;
  logic [2:0] otp_addr_pend_r;
  logic otp_loaded_r;
  logic [OTP_WIDTH-1:0] otp_shadow_r [OTP_WORDS];
  logic spike_over;
  logic release_seen;
  logic complete_done;
  display_reset_pkg::seq_state_t resume_r;
  logic ready_nxt;

  // Two flops before anything looks at the pin
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end
    else
    begin
      pin_meta_r <= reset_input_low_n_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Microsecond enable for the long completion timers
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      div_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (state_r == display_reset_pkg::ST_HELD && release_seen)
    begin
      // Grid restarts at confirmed release, so ready can never come up early
      div_cnt_r <= '0;
      tick_r <= 1'b0; // RULE12
    end
    else if (div_cnt_r == DW'(TICK_CYC - 1))
    begin
      div_cnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // Low width counts only while low; high time counts how long a high has lasted.
  // A high shorter than the reject width is treated as a spike and keeps the low count.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
    end
    else if (state_r == display_reset_pkg::ST_IDLE ||
             state_r == display_reset_pkg::ST_READY ||
             state_r == display_reset_pkg::ST_COMPLETE)
    begin
      low_cnt_r <= '0;
      high_cnt_r <= '0;
    end
    else if (!pin_sync_r)
    begin
      high_cnt_r <= '0; // RULE11
      if (low_cnt_r != PW'(VALID_CYC))
        low_cnt_r <= low_cnt_r + 1'b1;
    end
    else if (!spike_over)
      high_cnt_r <= high_cnt_r + 1'b1;
  end

  assign spike_over = (high_cnt_r == PW'(REJECT_CYC)); // RULE11
  assign release_seen = spike_over;
  assign complete_done = (us_cnt_r >= limit_r) && otp_loaded_r;
  // Ready holds while a pulse from the ready state is still being qualified
  assign ready_nxt = (state_r == display_reset_pkg::ST_READY) ||
                     (state_r == display_reset_pkg::ST_QUALIFY &&
                      resume_r == display_reset_pkg::ST_READY);

  // A rejected pulse must return the sequencer to the state it left
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      resume_r <= display_reset_pkg::ST_IDLE;
    else if (state_r != display_reset_pkg::ST_QUALIFY)
      resume_r <= state_r; // RULE1
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_r <= display_reset_pkg::ST_IDLE;
    else
    begin
      case (state_r)
        display_reset_pkg::ST_IDLE,
        display_reset_pkg::ST_READY:
          if (!pin_sync_r)
            state_r <= display_reset_pkg::ST_QUALIFY;
        display_reset_pkg::ST_QUALIFY:
          if (low_cnt_r == PW'(VALID_CYC))
            state_r <= display_reset_pkg::ST_HELD; // RULE1
          else if (release_seen)
            state_r <= resume_r; // RULE1 RULE2
        display_reset_pkg::ST_HELD:
          if (release_seen)
            state_r <= display_reset_pkg::ST_COMPLETE; // RULE11
        display_reset_pkg::ST_COMPLETE:
          if (!pin_sync_r)
            state_r <= display_reset_pkg::ST_QUALIFY;
          else if (complete_done)
            state_r <= display_reset_pkg::ST_READY; // RULE4
        default:
          state_r <= display_reset_pkg::ST_IDLE;
      endcase
    end
  end

  // Sleep state is caught when the reset is accepted and picks the completion limit
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sleep_out_r <= 1'b0;
      limit_r <= TW'(SLEEP_IN_US);
    end
    else if (state_r == display_reset_pkg::ST_QUALIFY && low_cnt_r == PW'(VALID_CYC))
    begin
      sleep_out_r <= sleep_out_in;
      limit_r <= sleep_out_in ? TW'(SLEEP_OUT_US) : TW'(SLEEP_IN_US); // RULE4
    end
  end

  // Release is confirmed one reject width after the rising edge, so the timer
  // starts with that time already counted to stay measured from the edge.
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      us_cnt_r <= '0;
    else if (state_r == display_reset_pkg::ST_HELD && release_seen)
      us_cnt_r <= TW'(REJECT_US); // RULE4
    else if (state_r == display_reset_pkg::ST_COMPLETE && tick_r && us_cnt_r < limit_r)
      us_cnt_r <= us_cnt_r + 1'b1;
  end

  // OTP copy runs at the start of completion, far inside the shortest limit
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      otp_idx_r <= '0;
      otp_pend_r <= 1'b0;
      otp_addr_pend_r <= '0;
      otp_loaded_r <= 1'b0;
      otp_req_out <= '0;
    end
    else if (state_r != display_reset_pkg::ST_COMPLETE)
    begin
      otp_idx_r <= '0;
      otp_pend_r <= 1'b0;
      otp_req_out <= '0;
      // Only an accepted reset discards the loaded copy
      if (state_r == display_reset_pkg::ST_HELD)
        otp_loaded_r <= 1'b0; // RULE6
    end
    else
    begin
      otp_pend_r <= otp_req_out.rd;
      otp_addr_pend_r <= otp_req_out.addr;
      if (otp_idx_r < 4'(OTP_WORDS) && !otp_loaded_r)
      begin
        otp_req_out.rd <= 1'b1; // RULE6
        otp_req_out.addr <= otp_idx_r[2:0];
        otp_idx_r <= otp_idx_r + 1'b1;
      end
      else
        otp_req_out.rd <= 1'b0;
      if (otp_pend_r && otp_addr_pend_r == 3'(OTP_WORDS - 1))
        otp_loaded_r <= 1'b1; // RULE6
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (otp_pend_r && state_r == display_reset_pkg::ST_COMPLETE)
      otp_shadow_r[otp_addr_pend_r] <= otp_data_in; // RULE6
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      cfg_word_out <= '0;
    else if (otp_loaded_r)
      cfg_word_out <= otp_shadow_r[cfg_sel_in];
    else
      cfg_word_out <= '0;
  end

  // After power-up nothing is ready until a hardware reset has completed
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      status_out <= '{ready: 1'b0, blank: 1'b1, core_reset: 1'b1,
                       otp_loaded: 1'b0, sleep_out_at_reset: 1'b0};
    else
    begin
      status_out.ready <= ready_nxt; // RULE12
      status_out.blank <= !ready_nxt; // RULE5
      status_out.core_reset <= (state_r == display_reset_pkg::ST_HELD) ||
                               (state_r == display_reset_pkg::ST_IDLE &&
                                !status_out.ready && status_out.core_reset); // RULE5
      status_out.otp_loaded <= otp_loaded_r;
      status_out.sleep_out_at_reset <= sleep_out_r;
    end
  end
endmodule // display_reset_sequencer

// [bench/otp_model.sv]
// OTP array model that answers each read one cycle after the request.
// Assumes requests come from the sequencer on mclk_in.
`timescale 1ns/1ns
module otp_model (
  input wire logic mclk_in,
  input wire display_reset_pkg::otp_req_t req_in,
  output logic [15:0] data_out = 16'h0f0f
);
  // Idle cycles toggle the bus so a late sample never looks valid
  always_ff @(posedge mclk_in)
  begin
    if (req_in.rd)
      data_out <= {12'hc3a, 1'b0, req_in.addr};
    else
      data_out <= ~data_out;
  end
endmodule // otp_model

// [bench/display_reset_assertions.sv]
// Port assertions for the display reset sequencer.
// Assumes one clock mclk_in and the asynchronous reset arst_n_in.
`timescale 1ns/1ns
module display_reset_checker #(
  parameter int SLEEP_IN_US = 5000,
  parameter int SLEEP_OUT_US = 120000,
  parameter int OTP_WORDS = 8,
  parameter int OTP_WIDTH = 16
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic reset_input_low_n_in,
  input wire logic sleep_out_in,
  input wire logic [OTP_WIDTH-1:0] otp_data_in,
  input wire logic [2:0] cfg_sel_in,
  input wire display_reset_pkg::otp_req_t otp_req_out,
  input wire logic [OTP_WIDTH-1:0] cfg_word_out,
  input wire display_reset_pkg::seq_status_t status_out
);
  logic [31:0] hi_r;
  logic [31:0] lo_r;
  int lim;
  assign lim = (status_out.sleep_out_at_reset ? SLEEP_OUT_US : SLEEP_IN_US) * 250;
  // Low time survives short highs, as the pin filter does
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      hi_r <= '0;
      lo_r <= '0;
    end
    else if (reset_input_low_n_in)
    begin
      hi_r <= (hi_r == '1) ? hi_r : hi_r + 32'h1;
      lo_r <= (hi_r >= 32'h4e1) ? '0 : lo_r;
    end
    else
    begin
      hi_r <= '0;
      lo_r <= lo_r + 32'h1;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  property p_ready_unblank;
    status_out.ready |-> !status_out.blank && status_out.otp_loaded;
  endproperty
  a_ready_unblank: assert property (p_ready_unblank)
    else $error("ready while blanked");
  property p_reset_blank;
    status_out.core_reset |-> status_out.blank && !status_out.ready;
  endproperty
  a_reset_blank: assert property (p_reset_blank)
    else $error("reset not blanked");
  property p_reject;
    $rose(status_out.core_reset) |-> lo_r >= 32'h9c4;
  endproperty
  a_reject: assert property (p_reject)
    else $error("short pulse accepted");
  property p_ready_keep;
    $fell(status_out.ready) |-> lo_r >= 32'h9c4;
  endproperty
  a_ready_keep: assert property (p_ready_keep)
    else $error("ready dropped without valid reset");
  property p_accept;
    lo_r == 32'h9ce |-> status_out.core_reset;
  endproperty
  a_accept: assert property (p_accept)
    else $error("long pulse not accepted");
  property p_spike;
    $fell(status_out.core_reset) && reset_input_low_n_in |-> hi_r >= 32'h4e2;
  endproperty
  a_spike: assert property (p_spike)
    else $error("reset ended by spike");
  property p_ready_time;
    $rose(status_out.ready) |-> hi_r >= lim && hi_r <= lim + 12;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("ready at wrong time");
  property p_otp_seq;
    otp_req_out.rd && otp_req_out.addr != 3'h7
      |=> otp_req_out.rd && otp_req_out.addr == $past(otp_req_out.addr) + 3'h1;
  endproperty
  a_otp_seq: assert property (p_otp_seq)
    else $error("otp read sequence broken");
  property p_otp_start;
    $rose(otp_req_out.rd) |-> otp_req_out.addr == 3'h0 && !status_out.core_reset;
  endproperty
  a_otp_start: assert property (p_otp_start)
    else $error("otp load started wrongly");
  property p_loaded;
    otp_req_out.rd && otp_req_out.addr == 3'h7 |-> ##[1:3] status_out.otp_loaded;
  endproperty
  a_loaded: assert property (p_loaded)
    else $error("otp load not flagged");
endmodule // display_reset_checker
bind display_reset_sequencer display_reset_checker #(.SLEEP_IN_US(SLEEP_IN_US),
  .SLEEP_OUT_US(SLEEP_OUT_US), .OTP_WORDS(OTP_WORDS), .OTP_WIDTH(OTP_WIDTH)) chk (
  .mclk_in, .arst_n_in, .reset_input_low_n_in, .sleep_out_in, .otp_data_in,
  .cfg_sel_in, .otp_req_out, .cfg_word_out, .status_out);

// [bench/tb.sv]
// Self-checking bench for the display reset sequencer.
// Assumes short completion limits by parameter and the OTP model beside it.
`timescale 1ns/1ns
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb;
  localparam int SIN = 20;
  localparam int SOUT = 40;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic pin_n = 1'b1;
  logic sleep_r = 1'b0;
  logic [2:0] sel_r = 3'h0;
  logic [15:0] otp_data;
  logic [15:0] cfg_word;
  display_reset_pkg::otp_req_t otp_req;
  display_reset_pkg::seq_status_t status;
  int num_errors = 0;
  int checked = 0;
  int rd_q[$];
  initial forever #2 mclk_in = ~mclk_in;
  display_reset_sequencer #(.SLEEP_IN_US(SIN), .SLEEP_OUT_US(SOUT)) uut (
    .mclk_in, .arst_n_in, .reset_input_low_n_in(pin_n), .sleep_out_in(sleep_r),
    .otp_data_in(otp_data), .cfg_sel_in(sel_r), .otp_req_out(otp_req),
    .cfg_word_out(cfg_word), .status_out(status));
  otp_model otp (.mclk_in, .req_in(otp_req), .data_out(otp_data));
  always @(posedge mclk_in) if (otp_req.rd === 1'b1) rd_q.push_back(otp_req.addr);
  task automatic final_report();
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge mclk_in);
  endtask
  task automatic pulse(input int lo, input int spike);
    @(posedge mclk_in);
    pin_n <= 1'b0;
    hold(lo / 2);
    if (spike > 0)
    begin
      pin_n <= 1'b1;
      hold(spike);
      pin_n <= 1'b0;
    end
    hold(lo - lo / 2);
    pin_n <= 1'b1;
  endtask
  task automatic full_reset(input logic so, input int spike);
    int lim;
    int n;
    int k;
    @(posedge mclk_in);
    // Sleep state only changes before a reset, never before the previous reset has reached ready
    sleep_r <= so;
    rd_q.delete();
    pulse(3000, spike);
    @(negedge mclk_in);
    `CHK("core_reset", 1'b1, status.core_reset)
    `CHK("blank", 1'b1, status.blank)
    lim = (so ? SOUT : SIN) * 250;
    // No command is sent before ready; the wait gives up after 12000 cycles
    for (n = 1; n < 12000 && status.ready !== 1'b1; n++) @(negedge mclk_in);
    if (n >= 12000)
    begin
      num_errors++;
      final_report();
    end
    `CHK("ready_time", 1'b1, n >= lim && n <= lim + 12)
    `CHK("otp_reads", 8, rd_q.size())
    `CHK("otp_loaded", 1'b1, status.otp_loaded)
    `CHK("blank_off", 1'b0, status.blank)
    `CHK("sleep_at_reset", so, status.sleep_out_at_reset)
    for (k = 0; k < rd_q.size(); k++) `CHK("otp_addr", k, rd_q[k])
    for (int i = 0; i < 8; i++)
    begin
      k = $urandom_range(7);
      @(posedge mclk_in);
      sel_r <= k[2:0];
      hold(2);
      @(negedge mclk_in);
      `CHK("cfg_word", 16'hc3a0 + k[15:0], cfg_word)
    end
  endtask
  initial
  begin
    void'($urandom(74));
    hold(10);
    arst_n_in <= 1'b1;
    @(negedge mclk_in);
    `CHK("ready_pwr", 1'b0, status.ready)
    `CHK("cfg_pwr", 16'h0000, cfg_word)
    for (int i = 1; i <= 2; i++)
    begin
      pulse(1000 * i, 0);
      hold(1500);
      @(negedge mclk_in);
      `CHK("ready_short", 1'b0, status.ready)
      `CHK("otp_short", 0, rd_q.size())
    end
    full_reset(1'b0, 500);
    full_reset(1'b1, 0);
    // A short pulse once ready must leave ready, blanking and the OTP copy alone
    pulse(1000, 0);
    hold(1500);
    @(negedge mclk_in);
    `CHK("ready_kept", 1'b1, status.ready)
    `CHK("blank_kept", 1'b0, status.blank)
    `CHK("otp_kept", 1'b1, status.otp_loaded)
    `CHK("otp_no_reload", 8, rd_q.size())
    final_report();
  end
endmodule // tb
